//--- hw/cancs_pkg.sv
/*
  Shared constants and types of the CAN control and status block.
  Assumes a 32-bit AXI4-Lite host bus with byte addresses.
*/
package cancs_pkg;
  // Bus geometry and responses
  localparam int         AXI_AW      = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;   // Mode control
  localparam logic [7:0] REG_STAT = 8'h04;   // Mode and irq status
  localparam logic [7:0] REG_LINK = 8'h08;   // Link error status
  localparam logic [7:0] REG_ISTS = 8'h0C;   // Sticky event status
  localparam logic [7:0] REG_IMSK = 8'h10;   // Event mask
  localparam logic [7:0] REG_ERRC = 8'h14;   // Error counts view

  // Decoded register index
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STAT = 3'h1;
  localparam logic [2:0] IDX_LINK = 3'h2;
  localparam logic [2:0] IDX_ISTS = 3'h3;
  localparam logic [2:0] IDX_IMSK = 3'h4;
  localparam logic [2:0] IDX_ERRC = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Field positions
  localparam int F_MODE  = 5;   // Mode fields, bits 7..5
  localparam int F_ABORT = 4;
  localparam int F_WIN   = 1;   // Window and code, bits 3..1
  localparam int F_OVF0  = 7;
  localparam int F_OVF1  = 6;

  // Operating modes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CONFIG = 3'h4;

  // Buffer and interrupt source codes
  localparam logic [2:0] CODE_WAKE = 3'h7;
  localparam logic [2:0] CODE_RECEIVE_BUFFER_0 = 3'h6;
  localparam logic [2:0] CODE_RECEIVE_BUFFER_1 = 3'h5;
  localparam logic [2:0] CODE_TRANSMIT_BUFFER_0 = 3'h4;
  localparam logic [2:0] CODE_TRANSMIT_BUFFER_1 = 3'h3;
  localparam logic [2:0] CODE_TRANSMIT_BUFFER_2 = 3'h2;
  localparam logic [2:0] CODE_ERR  = 3'h1;
  localparam logic [2:0] CODE_NONE = 3'h0;

  // Error count thresholds
  localparam logic [8:0] LIM_OFF  = 9'h0FF;
  localparam logic [8:0] LIM_PASS = 9'h07F;
  localparam logic [8:0] LIM_WARN = 9'h05F;

  // Sticky event bits
  localparam int IRQ_W    = 4;
  localparam int IRQ_OVF0 = 0;
  localparam int IRQ_OVF1 = 1;
  localparam int IRQ_BOFF = 2;
  localparam int IRQ_MODE = 3;

  // Pending interrupt sources from the buffers
  typedef struct packed {
    logic wake;
    logic receive_buffer_0;
    logic receive_buffer_1;
    logic transmit_buffer_0;
    logic transmit_buffer_1;
    logic transmit_buffer_2;
    logic err;
  } cancs_src_t;

  // Error counts from the protocol engine
  typedef struct packed {
    logic [8:0] tec;
    logic [7:0] rec;
  } cancs_errc_t;

  // Mode switch sequencer
  typedef enum {ST_RUN, ST_SWITCH} cancs_sw_t;
endpackage : cancs_pkg

//--- hw/cancs_ctrl.sv
/*
  CAN control and status registers behind an AXI4-Lite slave.
  Assumes a protocol engine that reports error counts, safe
  switch points and bus events synchronous to aclk.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Request top bit set means configuration mode
// - Status reports active mode, never reserved codes
// - Abort bit cancels all three transmit buffers
// - Window code selects one mapped buffer
// - Code shows highest priority pending source
// - Code and window share bits three to one
// - Buffer 0 overflow flag sticks until cleared
// - Buffer 1 overflow flag sticks until cleared
// - Bus-off flag when transmit count above 255
// - Transmit passive when count above 127
// - Receive passive when count above 127
// - Transmit warning for counts 96 to 127
// - Receive warning for counts 96 to 127
// - Combined warning is OR of both
// - Unimplemented bits read as zero
// - Count overflow enters bus-off, 128 runs clear
module cancs_ctrl
  import cancs_pkg::*;
#(
  parameter int BUSOFF_RUNS = 128              // Recessive runs to leave bus-off
) (
  input  wire logic              aclk,        // Clock, 20 MHz
  input  wire logic              aresetn,     // Sync reset, active low
  input  wire logic              ce,          // Clock enable
  input  wire logic [AXI_AW-1:0] awaddr,      // Write address
  input  wire logic              awvalid,     // Write address valid
  output logic                   awready,     // Write address ready
  input  wire logic [31:0]       wdata,       // Write data
  input  wire logic [3:0]        wstrb,       // Write strobes
  input  wire logic              wvalid,      // Write data valid
  output logic                   wready,      // Write data ready
  output logic [1:0]             bresp,       // Write response
  output logic                   bvalid,      // Write response valid
  input  wire logic              bready,      // Write response ready
  input  wire logic [AXI_AW-1:0] araddr,      // Read address
  input  wire logic              arvalid,     // Read address valid
  output logic                   arready,     // Read address ready
  output logic [31:0]            rdata,       // Read data
  output logic [1:0]             rresp,       // Read response
  output logic                   rvalid,      // Read data valid
  input  wire logic              rready,      // Read data ready
  input  wire logic              safe_point,  // Engine may switch mode
  input  wire cancs_errc_t       errc,        // Error counts
  input  wire logic              run11_pulse, // Eleven recessive bits seen
  input  wire logic              ovf0_evt,    // Receive buffer 0 overflow
  input  wire logic              ovf1_evt,    // Receive buffer 1 overflow
  input  wire cancs_src_t        src,         // Pending buffer sources
  input  wire logic              abort_done,  // All aborts finished
  output logic [2:0]             op_mode,     // Mode in effect
  output logic                   abort_all,   // Abort every transmit buffer
  output logic [4:0]             win_onehot,  // Mapped buffer select
  output logic                   bus_off,     // Bus-off state
  output logic                   tec_clear,   // Clear transmit count
  output logic                   irq          // Interrupt, active high
);

  localparam int RUN_W = $clog2(BUSOFF_RUNS);

  // Refuse run counts the counter cannot serve
  if (BUSOFF_RUNS < 2) begin : g_chk
    $error("BUSOFF_RUNS must be at least 2");
  end

  // Map an address onto a register index
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    if (a == REG_CTRL)      reg_idx = IDX_CTRL;
    else if (a == REG_STAT) reg_idx = IDX_STAT;
    else if (a == REG_LINK) reg_idx = IDX_LINK;
    else if (a == REG_ISTS) reg_idx = IDX_ISTS;
    else if (a == REG_IMSK) reg_idx = IDX_IMSK;
    else if (a == REG_ERRC) reg_idx = IDX_ERRC;
    else                    reg_idx = IDX_NONE;
  endfunction : reg_idx

  // Buffer code to one-hot window, bit order receive_buffer_0..transmit_buffer_2
  function automatic logic [4:0] win_dec(input logic [2:0] c);
    if (c == CODE_RECEIVE_BUFFER_1)      win_dec = 5'h02;
    else if (c == CODE_TRANSMIT_BUFFER_0) win_dec = 5'h04;
    else if (c == CODE_TRANSMIT_BUFFER_1) win_dec = 5'h08;
    else if (c == CODE_TRANSMIT_BUFFER_2) win_dec = 5'h10;
    else                     win_dec = 5'h01; // All others map buffer 0
  endfunction : win_dec

  // Fixed priority, wake-up highest, error lowest
  function automatic logic [2:0] prio(input cancs_src_t s);
    if (s.wake)      prio = CODE_WAKE;
    else if (s.receive_buffer_0) prio = CODE_RECEIVE_BUFFER_0;
    else if (s.receive_buffer_1) prio = CODE_RECEIVE_BUFFER_1;
    else if (s.transmit_buffer_0) prio = CODE_TRANSMIT_BUFFER_0;
    else if (s.transmit_buffer_1) prio = CODE_TRANSMIT_BUFFER_1;
    else if (s.transmit_buffer_2) prio = CODE_TRANSMIT_BUFFER_2;
    else if (s.err)  prio = CODE_ERR;
    else             prio = CODE_NONE;
  endfunction : prio

  // Software state
  logic [2:0]       req_mode;   // Raw mode request
  logic [2:0]       win;        // Window select
  logic [1:0]       link_ovf;   // Overflow flags, 1 is buffer 0
  logic [IRQ_W-1:0] irq_sts;    // Sticky events
  logic [IRQ_W-1:0] irq_msk;    // Event mask
  // Hardware state
  cancs_sw_t        state;      // Mode switch sequencer
  logic [RUN_W-1:0] run_cnt;    // Recessive runs in bus-off
  // Bus holding state
  logic             aw_got;     // Address held
  logic             w_got;      // Data held
  logic [7:0]       waddr;      // Held address
  logic [7:0]       wbyte;      // Held low data byte
  logic             wlane;      // Held low byte strobe

  // Bus handshakes
  wire aw_fire = awvalid & awready;
  wire w_fire  = wvalid & wready;
  wire ar_fire = arvalid & arready;
  wire wr_do   = aw_got & w_got & ~bvalid;

  // Write decode, low byte lane only carries data
  wire [2:0] widx    = reg_idx(waddr);
  wire       wr_hit  = wr_do & (widx != IDX_NONE);
  wire       wr_ctrl = wr_hit & wlane & (widx == IDX_CTRL);
  wire       wr_link = wr_hit & wlane & (widx == IDX_LINK);
  wire       wr_ists = wr_hit & wlane & (widx == IDX_ISTS);
  wire       wr_imsk = wr_hit & wlane & (widx == IDX_IMSK);

  // Next bus state
  wire next_aw_got = aw_fire | (aw_got & ~wr_do);
  wire next_w_got  = w_fire | (w_got & ~wr_do);
  wire next_bvalid = wr_do | (bvalid & ~bready);
  wire next_rvalid = ar_fire | (rvalid & ~rready);

  // Requested mode, top bit forces configuration
  wire [2:0] req_dec = req_mode[2] ? MODE_CONFIG : req_mode;

  // Switch lands only where the engine allows it
  wire mode_load = (state == ST_SWITCH) & safe_point;

  // Error state flags from the live counts
  wire tx_bo = errc.tec > LIM_OFF;
  wire tx_bp = errc.tec > LIM_PASS;
  wire rx_bp = {1'b0, errc.rec} > LIM_PASS;
  wire tx_w  = (errc.tec > LIM_WARN) & ~tx_bp;
  wire rx_w  = ({1'b0, errc.rec} > LIM_WARN) & ~rx_bp;
  wire ew    = tx_w | rx_w;

  // Bus-off entry and exit
  wire boff_set  = tx_bo & ~bus_off & ~tec_clear;
  wire run_last  = run_cnt == RUN_W'(BUSOFF_RUNS - 1);
  wire boff_exit = bus_off & run11_pulse & run_last;

  // Source code shares the window field position
  wire [2:0] icode = prio(src);

  // Overflow flags, event wins over clear
  wire [1:0] ovf_evt  = {ovf0_evt, ovf1_evt};
  wire [1:0] ovf_clr  = wr_link ? wbyte[F_OVF0:F_OVF1] : 2'h0;
  wire [1:0] next_ovf = (link_ovf & ~ovf_clr) | ovf_evt;

  // Sticky events, set wins over write-one-clear
  logic [IRQ_W-1:0] ev;
  always_comb begin
    ev           = '0;
    ev[IRQ_OVF0] = ovf0_evt;
    ev[IRQ_OVF1] = ovf1_evt;
    ev[IRQ_BOFF] = boff_set;
    ev[IRQ_MODE] = mode_load;
  end
  wire [IRQ_W-1:0] ists_clr  = wr_ists ? wbyte[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_ists = (irq_sts & ~ists_clr) | ev;

  // Read views, unimplemented bits tied low
  wire [7:0] ctrl_rd = {req_mode, abort_all, win, 1'b0};
  wire [7:0] stat_rd = {op_mode, 1'b0, icode, 1'b0};
  wire [7:0] link_rd = {link_ovf, tx_bo, tx_bp, rx_bp, tx_w, rx_w, ew};

  // Read mux on the address offered
  wire [2:0] ridx = reg_idx(araddr);
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ridx == IDX_CTRL)      rd_word[7:0] = ctrl_rd;
    else if (ridx == IDX_STAT) rd_word[7:0] = stat_rd;
    else if (ridx == IDX_LINK) rd_word[7:0] = link_rd;
    else if (ridx == IDX_ISTS) rd_word[IRQ_W-1:0] = irq_sts;
    else if (ridx == IDX_IMSK) rd_word[IRQ_W-1:0] = irq_msk;
    else if (ridx == IDX_ERRC) rd_word[16:0] = errc;
  end

  // Write channels; one write in flight, response after both
  // The readies freeze with the rest of the state while ce is low, and a handshake
  // seen then is lost, so ce must stay high while the bus is busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      waddr   <= 8'h00;
      wbyte   <= 8'h00;
      wlane   <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_fire) waddr <= awaddr;
      if (w_fire) begin
        wbyte <= wdata[7:0];
        wlane <= wstrb[0];
      end
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      awready <= ~next_aw_got & ~next_bvalid;
      wready  <= ~next_w_got & ~next_bvalid;
      bvalid  <= next_bvalid;
      if (wr_do) bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read channel; data captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_fire) begin
        rdata <= rd_word;
        rresp <= (ridx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Control fields; abort stays up until the engine is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_mode  <= MODE_CONFIG;
      win       <= CODE_NONE;
      abort_all <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        req_mode  <= wbyte[F_MODE+2:F_MODE];
        win       <= wbyte[F_WIN+2:F_WIN];
        abort_all <= wbyte[F_ABORT];
      end else if (abort_done) begin
        abort_all <= 1'b0;
      end
    end
  end

  // Mode sequencer; a request is parked until a safe point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_RUN;
      op_mode <= MODE_CONFIG;
    end else if (ce) begin
      case (state)
        ST_RUN: begin
          if (req_dec != op_mode) state <= ST_SWITCH;
        end
        ST_SWITCH: begin
          if (safe_point) begin
            op_mode <= req_dec;
            state   <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Bus-off tracking; exit pulses the count clear once
  // Entry is blocked while the clear pulse stands, because the engine still
  // shows the old count in that cycle and would send the block straight back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_off   <= 1'b0;
      run_cnt   <= '0;
      tec_clear <= 1'b0;
    end else if (ce) begin
      tec_clear <= boff_exit;
      if (boff_set) begin
        bus_off <= 1'b1;
        run_cnt <= '0;
      end else if (boff_exit) begin
        bus_off <= 1'b0;
        run_cnt <= '0;
      end else if (bus_off & run11_pulse) begin
        run_cnt <= run_cnt + 1'b1;
      end
    end
  end

  // Flags, mask, window and interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_ovf   <= 2'h0;
      irq_sts    <= '0;
      irq_msk    <= '0;
      win_onehot <= 5'h01;
      irq        <= 1'b0;
    end else if (ce) begin
      link_ovf   <= next_ovf;
      irq_sts    <= next_ists;
      if (wr_imsk) irq_msk <= wbyte[IRQ_W-1:0];
      win_onehot <= win_dec(win);
      // Level output lags the status by one cycle
      irq        <= |(irq_sts & irq_msk);
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_rsvd_a: assert property (op_mode <= MODE_CONFIG)
    else $error("reserved mode reported");
  mode_safe_a: assert property (ce && !$stable(op_mode) |-> $past(safe_point))
    else $error("mode changed without safe point");
  cfg_req_a: assert property (ce && mode_load && req_mode[2] |=> op_mode == MODE_CONFIG)
    else $error("config request not honoured");
  abort_set_a: assert property (ce && wr_ctrl && wbyte[F_ABORT] |=> abort_all)
    else $error("abort bit not raised");
  win_hot_a: assert property ($onehot(win_onehot))
    else $error("window select not one-hot");
  wake_prio_a: assert property (src.wake |-> stat_rd[F_WIN+2:F_WIN] == CODE_WAKE)
    else $error("wake-up not top priority");
  ovf0_hold_a: assert property (ce && link_ovf[1] && !ovf_clr[1] |=> link_ovf[1])
    else $error("overflow 0 flag lost");
  ovf1_set_a: assert property (ce && ovf1_evt |=> link_ovf[0])
    else $error("overflow 1 flag not set");
  warn_pass_a: assert property (!(tx_w && tx_bp) && !(rx_w && rx_bp))
    else $error("warning and passive together");
  boff_enter_a: assert property (ce && boff_set |=> bus_off && irq_sts[IRQ_BOFF])
    else $error("bus-off not entered");
  boff_clear_a: assert property (tec_clear |-> !bus_off && $past(bus_off))
    else $error("count clear outside bus-off exit");
  zero_bits_a: assert property (rvalid && rresp == RESP_OKAY |-> rdata[31:17] == 15'h0000)
    else $error("unused read bits not zero");

  // Checks on the values that a read actually returns and on the held state
  mode_code_a: assert property (ce && mode_load |=> op_mode == $past(req_dec))
    else $error("mode switch took wrong code");
  abort_hold_a: assert property (ce && abort_all && !wr_ctrl && !abort_done |=> abort_all)
    else $error("abort dropped early");
  win_transmit_buffer_2_a: assert property (ce && win == CODE_TRANSMIT_BUFFER_2 |=> win_onehot[4])
    else $error("transmit buffer 2 not mapped");
  ovf0_clr_a: assert property (ce && wr_link && wbyte[F_OVF0] && !ovf0_evt |=> !link_ovf[1])
    else $error("overflow 0 flag not cleared");
  ovf0_set_a: assert property (ce && ovf0_evt |=> link_ovf[1] && irq_sts[IRQ_OVF0])
    else $error("overflow 0 flag not set");
  boff_exit_a: assert property (ce && boff_exit |=> !bus_off && tec_clear)
    else $error("bus-off not left");
  ctrl_zero_a: assert property (ce && ar_fire && ridx == IDX_CTRL |=> !rdata[0])
    else $error("control bit 0 not zero");
  stat_zero_a: assert property (ce && ar_fire && ridx == IDX_STAT |=> !rdata[4] && !rdata[0])
    else $error("status unused bits not zero");
  link_boff_a: assert property (ce && ar_fire && ridx == IDX_LINK |=> rdata[5] == $past(errc.tec > LIM_OFF))
    else $error("bus-off flag wrong");
  link_ew_a: assert property (ce && ar_fire && ridx == IDX_LINK |=> rdata[0] == (rdata[2] | rdata[1]))
    else $error("combined warning wrong");

endmodule : cancs_ctrl

//--- verification/cancs_engine_model.sv
/*
  Engine-side model for the CAN control block: error counts, safe
  points, recessive runs and abort completion.
  Assumes the bench sets the knobs right after a rising edge.
*/
`timescale 1ns/1ps
module cancs_engine_model
  import cancs_pkg::*;
(
  input  wire logic        aclk,        // Clock
  input  wire logic        aresetn,     // Sync reset, active low
  input  wire logic        sp_en,       // Allow safe points
  input  wire logic        run_en,      // Produce recessive runs
  input  wire logic        tec_load,    // Load transmit count
  input  wire logic [8:0]  tec_val,     // Transmit count to load
  input  wire logic [7:0]  rec_val,     // Receive count
  input  wire logic        tec_clear,   // Clear request from block
  input  wire logic        abort_all,   // Abort request from block
  input  wire logic        bus_off,     // Bus-off state of block
  output cancs_errc_t      errc,        // Error counts
  output logic             safe_point,  // Mode switch allowed
  output logic             run11_pulse, // Eleven recessive bits
  output logic             abort_done   // Abort finished
);
  logic [8:0] tec;     // Transmit count held by the engine
  logic [2:0] tick;    // Free phase counter, spaces the pulses
  logic [3:0] ab_cnt;  // Cycles the abort has been pending

  // Clear wins over load, the block expects the count gone at tec_clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tec <= 9'h000;
      tick <= 3'h0;
      ab_cnt <= 4'h0;
    end else begin
      tick <= tick + 3'h1;
      ab_cnt <= abort_all ? ab_cnt + 4'h1 : 4'h0;
      if (tec_clear) begin
        tec <= 9'h000;
      end else if (tec_load) begin
        tec <= tec_val;
      end
    end
  end

  // Pulses come one cycle in four, so the block never sees them back to back
  assign errc        = '{tec: tec, rec: rec_val};
  assign safe_point  = sp_en && tick[1:0] == 2'h3;
  assign run11_pulse = run_en && bus_off && tick[1:0] == 2'h1;
  // Abort takes six cycles, so a stuck abort_all is visible first
  assign abort_done  = ab_cnt == 4'h6;
endmodule : cancs_engine_model

//--- verification/tb_can_control_status.sv
/*
  Self-checking bench for cancs_ctrl over AXI4-Lite, random and corner stimulus.
  Assumes cancs_engine_model on the engine side and ce held high.
*/
`timescale 1ns/1ps
module tb_can_control_status;
  import cancs_pkg::*;
  localparam int RUNS = 4;  // Short bus-off recovery for simulation
  logic aclk = 0, aresetn = 0, ce = 1, bready = 1, rready = 1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rec_val = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, arvalid = 0, ovf0_evt = 0, ovf1_evt = 0;
  logic sp_en = 0, run_en = 0, tec_load = 0;
  logic [8:0] tec_val = 9'h000;
  cancs_src_t src = '0;
  cancs_errc_t errc;
  logic awready, wready, bvalid, arready, rvalid, safe_point, run11_pulse;
  logic abort_done, abort_all, bus_off, tec_clear, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] op_mode;
  logic [4:0] win_onehot;
  int failures = 0, cmp_count = 0;
  logic [8:0] tc [6] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};  // Count corners
  logic [7:0] rc [6] = '{8'h60, 8'h5F, 8'h80, 8'h7F, 8'hFF, 8'h00};

  always #25 aclk = ~aclk;  // 20 MHz

  cancs_ctrl #(.BUSOFF_RUNS(RUNS)) dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .safe_point, .errc, .run11_pulse, .ovf0_evt, .ovf1_evt,
    .src, .abort_done, .op_mode, .abort_all, .win_onehot, .bus_off, .tec_clear, .irq);
  cancs_engine_model eng (.aclk, .aresetn, .sp_en, .run_en, .tec_load, .tec_val, .rec_val,
    .tec_clear, .abort_all, .bus_off, .errc, .safe_point, .run11_pulse, .abort_done);

  // Mode in effect for a request
  function automatic logic [2:0] exp_mode(input logic [2:0] q);
    return q[2] ? 3'h4 : q;
  endfunction : exp_mode
  // One-hot buffer for a window code, unused codes fall back to receive buffer 0
  function automatic logic [4:0] exp_win(input logic [2:0] w);
    case (w)
      3'h5: return 5'h02;
      3'h4: return 5'h04;
      3'h3: return 5'h08;
      3'h2: return 5'h10;
      default: return 5'h01;
    endcase
  endfunction : exp_win
  // Highest set source wins; bit b maps to code b+1
  function automatic logic [2:0] exp_code(input cancs_src_t s);
    for (int b = 6; b >= 0; b--) if (s[b]) return 3'(b + 1);
    return 3'h0;
  endfunction : exp_code
  function automatic logic [5:0] exp_link(input logic [8:0] t, input logic [7:0] q);
    logic tw, rw;
    tw = t > 95 && t <= 127;
    rw = q > 95 && q <= 127;
    return {t > 255, t > 127, q > 127, tw, rw, tw | rw};
  endfunction : exp_link

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task report_and_stop();
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Each channel is released at its own handshake; bready stays high throughout
  // Waits as long as the slave takes; only the watchdog ends a hung transfer
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit pa, pw;
    pa = 1;
    pw = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 0;
        awvalid <= 1'h0;
      end
      if (pw && wready) begin
        pw = 0;
        wvalid <= 1'h0;
      end
    end while (!(bvalid && !pa && !pw));
    r = bresp;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit pa;
    pa = 1;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (pa && arready) begin
        pa = 0;
        arvalid <= 1'h0;
      end
    end while (!(rvalid && !pa));
    d = rdata;
    r = rresp;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask : rchk
  task set_cnt(input logic [8:0] t, input logic [7:0] q);
    tec_val <= t;
    rec_val <= q;
    tec_load <= 1'h1;
    @(posedge aclk);
    tec_load <= 1'h0;
    @(posedge aclk);
  endtask : set_cnt

  // Watchdog: the tests need a few hundred cycles, the limit is 20000
  initial begin
    #(50 * 20000);
    failures++;
    report_and_stop();
  end

  initial begin
    logic [31:0] d, sv;
    logic [1:0] r;
    logic [2:0] m;
    int k;
    d = $urandom(32'h898B);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(REG_CTRL, 32'h80);
    rchk(REG_STAT, 32'h80);
    wr(REG_CTRL, 32'h00, r);
    repeat (6) @(posedge aclk);
    rchk(REG_STAT, 32'h80);
    sp_en <= 1'h1;
    // Every request code, polled until the status follows
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(REG_CTRL, {24'h0, m, 5'h00}, r);
      k = 0;
      do begin
        rd(REG_STAT, d, r);
        k++;
      end while (d[7:5] !== exp_mode(m) && k < 20);
      chk(d, {24'h0, exp_mode(m), 5'h00});
      chk(op_mode, exp_mode(m));
    end
    // Every window code, with the unused low bit written as one
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(REG_CTRL, {24'h0, 4'h8, m, 1'h1}, r);
      @(posedge aclk);
      chk(win_onehot, exp_win(m));
      rchk(REG_CTRL, {24'h0, 4'h8, m, 1'h0});
    end
    wr(REG_CTRL, 32'h90, r);
    @(posedge aclk);
    chk(abort_all, 1'h1);
    repeat (10) @(posedge aclk);
    chk(abort_all, 1'h0);
    // A write without the low byte strobe must leave the control register alone
    wstrb <= 4'hE;
    wr(REG_CTRL, 32'h1E, r);
    wstrb <= 4'hF;
    rchk(REG_CTRL, 32'h80);
    // Handler style: save window, snapshot status, map the source, restore
    for (int i = 0; i < 16; i++) begin
      src <= (i < 7) ? 7'(1 << i) : 7'($urandom);
      @(posedge aclk);
      rd(REG_CTRL, sv, r);
      rd(REG_STAT, d, r);
      chk(d[3:1], exp_code(src));
      wr(REG_CTRL, (sv & 32'hF1) | (d & 32'h0E), r);
      @(posedge aclk);
      chk(win_onehot, exp_win(exp_code(src)));
      wr(REG_CTRL, sv, r);
      rchk(REG_CTRL, sv);
    end
    src <= '0;
    // Error flags for corner counts, then random counts
    for (int i = 0; i < 24; i++) begin
      set_cnt(i < 6 ? tc[i] : 9'($urandom), i < 6 ? rc[i] : 8'($urandom));
      rd(REG_LINK, d, r);
      chk(d[5:0], exp_link(tec_val, rec_val));
    end
    // Corner counts left the block in bus-off: recover, clear the event, enter afresh
    run_en <= 1'h1;
    for (int n = 0; n < 200 && !tec_clear; n++) @(posedge aclk);
    run_en <= 1'h0;
    @(posedge aclk);
    chk(bus_off, 1'h0);
    wr(REG_ISTS, 32'h04, r);
    set_cnt(9'h100, 8'h00);
    @(posedge aclk);
    chk(bus_off, 1'h1);
    rd(REG_ISTS, d, r);
    chk(d[2], 1'h1);
    run_en <= 1'h1;
    k = 0;
    for (int n = 0; n < 200 && !tec_clear; n++) begin
      @(posedge aclk);
      if (run11_pulse) k++;
    end
    chk(k, RUNS);
    chk(bus_off, 1'h0);
    run_en <= 1'h0;
    rd(REG_ERRC, d, r);
    chk(d[16:8], 9'h000);
    // Sticky overflows, one masked in, cleared one at a time
    wr(REG_ISTS, 32'h0F, r);
    wr(REG_IMSK, 32'h01, r);
    ovf0_evt <= 1'h1;
    ovf1_evt <= 1'h1;
    @(posedge aclk);
    ovf0_evt <= 1'h0;
    ovf1_evt <= 1'h0;
    repeat (5) @(posedge aclk);
    chk(irq, 1'h1);
    rd(REG_LINK, d, r);
    chk(d[7:6], 2'h3);
    wr(REG_LINK, 32'h80, r);
    rd(REG_LINK, d, r);
    chk(d[7:6], 2'h1);
    wr(REG_LINK, 32'h40, r);
    rd(REG_LINK, d, r);
    chk(d[7:6], 2'h0);
    wr(REG_ISTS, 32'h01, r);
    repeat (3) @(posedge aclk);
    chk(irq, 1'h0);
    wr(REG_STAT, 32'hFF, r);
    rchk(REG_STAT, 32'h80);
    rd(8'h1C, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h1C, 32'hFF, r);
    chk(r, RESP_SLVERR);
    report_and_stop();
  end
endmodule : tb_can_control_status
